/* File: hw/acq_trig_regs.svh */
`ifndef ACQ_TRIG_REGS_SVH
`define ACQ_TRIG_REGS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_TRIG_CFG 8'h04
`define REG_BURST 8'h08
`define REG_RATE 8'h0c
`define REG_CMD 8'h10
`define REG_STATUS 8'h14
`define REG_MISSED 8'h18
`define REG_TOTAL 8'h1c
`define REG_PERIOD 8'h20

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_MSB 3
`define CTRL_ACQ_TRIG_EN 0
`define CTRL_FRAME_TRIG_EN 1
`define CTRL_RATE_EN 2
`define CTRL_RUN_MODE 3
`define CFG_MSB 7
`define CFG_ACQ_ORIGIN_LSB 0
`define CFG_ACQ_EDGE 2
`define CFG_FRAME_ORIGIN_LSB 4
`define CFG_FRAME_EDGE 6
`define ORIGIN_BITS 2
`define CMD_ACQ_SW 0
`define CMD_FRAME_SW 1
`define CMD_ABORT 2
`define STATUS_STATE_LSB 0
`define STATUS_EXPOSE 2
`define STATUS_COUNT_LSB 16
`define COUNT_MSB 15

// ----------------------------------------
// reset values
// ----------------------------------------
`define CTRL_RESET 4'h0
`define CFG_RESET 8'h00
`define BURST_RESET 16'h0001
`define RATE_RESET 32'h0000_0100
`define COUNT_RESET 16'h0000
`define TOTAL_RESET 32'h0000_0000
`define DATA_RESET 32'h0000_0000

// ----------------------------------------
// timing counts in clk cycles, plus burst minimum and step sizes
// ----------------------------------------
`define EXPOSE_CYCLES 16'h0040
`define MIN_FRAME_CYCLES 32'h0000_0050
`define BURST_MIN 16'h0001
`define COUNT_STEP 16'h0001
`define PERIOD_STEP 32'h0000_0001

`endif

/* File: hw/acq_trig_pkg.sv */
`default_nettype none

package acq_trig_pkg;

  // ----------------------------------------
  // sequencer states, gray except the st_expose to st_wait_acq step
  // ----------------------------------------
  typedef enum logic [1:0] {
    st_wait_acq = 2'b00,
    st_wait_frame = 2'b01,
    st_expose = 2'b11
  } seq_state_e;

  typedef enum logic [1:0] {
    origin_line_one = 2'b00,
    origin_line_two = 2'b01,
    origin_software = 2'b10
  } trig_origin_e;

  typedef enum logic {
    edge_up = 1'b0,
    edge_down = 1'b1
  } trig_edge_e;

endpackage

`default_nettype wire

/* File: hw/seq_if.sv */
`default_nettype none

interface seq_if;
  logic [1:0] rise;
  logic [1:0] fall;
  logic rate_run;
  logic [31:0] rate_period;
  logic rate_tick;

  modport edge_src (output rise, output fall);
  modport rate_src (input rate_run, input rate_period, output rate_tick);
  modport core (input rise, input fall, output rate_run, output rate_period, input rate_tick);
endinterface

`default_nettype wire

/* File: hw/edge_sync.sv */
`default_nettype none

module edge_sync
  import acq_trig_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0] pins,
  seq_if.edge_src evt
);

  // ----------------------------------------
  // two-flop synchroniser, then edge detect
  // ----------------------------------------
  // limitation: a line already high at reset release reports one rise
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_line
      logic meta, stable, last, rise_q, fall_q;
      logic next_meta, next_stable, next_last, next_rise, next_fall;

      always_comb begin
        next_meta = pins[i];
        next_stable = meta;
        next_last = stable;
        next_rise = stable & ~last;
        next_fall = ~stable & last;
      end

      always_ff @(posedge clk) begin
        if (!nrst) begin
          meta <= 1'b0;
          stable <= 1'b0;
          last <= 1'b0;
          rise_q <= 1'b0;
          fall_q <= 1'b0;
        end else begin
          meta <= next_meta;
          stable <= next_stable;
          last <= next_last;
          rise_q <= next_rise;
          fall_q <= next_fall;
        end
      end

      assign evt.rise[i] = rise_q;
      assign evt.fall[i] = fall_q;
    end
  endgenerate

endmodule

`default_nettype wire

/* File: hw/frame_rate_gen.sv */
`default_nettype none
`include "acq_trig_regs.svh"

module frame_rate_gen
  import acq_trig_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  seq_if.rate_src rate
);

  // ----------------------------------------
  // internal frame start ticker
  // ----------------------------------------
  // the count keeps draining while idle, so a pause never shortens
  // the spacing between two ticks below the programmed period
  logic [31:0] cnt, next_cnt;
  logic tick, next_tick;

  always_comb begin
    next_cnt = cnt;
    next_tick = 1'b0;
    if (cnt != `DATA_RESET) begin
      next_cnt = cnt - `PERIOD_STEP;
    end else if (rate.rate_run) begin
      next_tick = 1'b1;
      next_cnt = rate.rate_period - `PERIOD_STEP;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt <= `DATA_RESET;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end

  assign rate.rate_tick = tick;

endmodule

`default_nettype wire

/* File: hw/acquisition_trigger_sequencer.sv */
// Operation
// - with acquisition triggering on, stay waiting until the selected start trigger arrives.
// - a selected line edge moves waiting-for-start to waiting-for-frame.
// - after the programmed frame count, return to waiting for acquisition start.
// - once back waiting, capture nothing until a fresh acquisition start trigger.
// - with frame triggering off, frame starts are made internally while waiting for frame.
// - internal frame starts follow the programmed period unless the minimum forces slower.
// - with the programmed rate disabled, run at the fastest allowed frame rate.
// - while waiting for acquisition start, all frame triggers are ignored.
// - with software origin, the host acquisition command is the start trigger.
// - with frame triggering on, each selected line edge begins one frame.
// - frame triggers are accepted only while waiting for frame; others are dropped.
// - count each accepted frame trigger; at the programmed count go back waiting.
// - both triggers off in continuous mode gives free-running acquisition.
//
// The placing of the registers and the APB slave port were left to the implementer.
`default_nettype none
`include "acq_trig_regs.svh"

module acquisition_trigger_sequencer
  import acq_trig_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic ext_input_one,
  input wire logic ext_input_two,
  output logic frame_start,
  output logic exposure_active,
  output logic acq_waiting,
  output logic frame_waiting
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [3:0] ctrl, next_ctrl;
  logic [7:0] trig_cfg, next_trig_cfg;
  logic [15:0] frames_per_burst, next_frames_per_burst;
  logic [31:0] internal_frame_rate, next_internal_frame_rate;
  logic sw_acq, next_sw_acq;
  logic sw_frame, next_sw_frame;
  logic sw_abort, next_sw_abort;
  logic [31:0] prdata_q, next_prdata;
  logic pslverr_q, next_pslverr;

  seq_state_e state, next_state;
  logic [15:0] frame_cnt, next_frame_cnt;
  logic [15:0] expose_cnt, next_expose_cnt;
  logic [15:0] missed_triggers, next_missed_triggers;
  logic [31:0] total_frames, next_total_frames;
  logic frame_start_q, next_frame_start;

  seq_if link ();

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  edge_sync u_edge_sync (
    .clk(clk),
    .nrst(nrst),
    .pins({ext_input_two, ext_input_one}),
    .evt(link.edge_src)
  );

  frame_rate_gen u_frame_rate_gen (
    .clk(clk),
    .nrst(nrst),
    .rate(link.rate_src)
  );

  // ----------------------------------------
  // configuration decode
  // ----------------------------------------
  logic acq_trig_enable_sel;
  logic frame_trig_enable_sel;
  logic rate_enable;
  logic acq_run_mode;
  trig_origin_e acq_trig_origin_sel;
  trig_origin_e frame_trig_origin_sel;
  trig_edge_e acq_trig_edge_sel;
  trig_edge_e frame_trig_edge_sel;
  logic [15:0] burst_target;
  logic [31:0] frame_period;

  assign acq_trig_enable_sel = ctrl[`CTRL_ACQ_TRIG_EN];
  assign frame_trig_enable_sel = ctrl[`CTRL_FRAME_TRIG_EN];
  assign rate_enable = ctrl[`CTRL_RATE_EN];
  assign acq_run_mode = ctrl[`CTRL_RUN_MODE];
  assign acq_trig_origin_sel = trig_origin_e'(trig_cfg[`CFG_ACQ_ORIGIN_LSB +: `ORIGIN_BITS]);
  assign frame_trig_origin_sel = trig_origin_e'(trig_cfg[`CFG_FRAME_ORIGIN_LSB +: `ORIGIN_BITS]);
  assign acq_trig_edge_sel = trig_edge_e'(trig_cfg[`CFG_ACQ_EDGE]);
  assign frame_trig_edge_sel = trig_edge_e'(trig_cfg[`CFG_FRAME_EDGE]);

  // single-frame mode ends every burst after one frame; zero reads as one
  always_comb begin
    if (acq_run_mode || frames_per_burst == `COUNT_RESET) begin
      burst_target = `BURST_MIN;
    end else begin
      burst_target = frames_per_burst;
    end
  end

  // the fixed MIN_FRAME_CYCLES (exposure plus overhead) bounds the period from below
  always_comb begin
    if (rate_enable && internal_frame_rate > `MIN_FRAME_CYCLES) begin
      frame_period = internal_frame_rate;
    end else begin
      frame_period = `MIN_FRAME_CYCLES;
    end
  end

  assign link.rate_period = frame_period;
  assign link.rate_run = (state != st_wait_acq) && !frame_trig_enable_sel;

  // ----------------------------------------
  // trigger selection
  // ----------------------------------------
  // only synchronised edges are seen: a line pulse shorter than
  // one clock may be lost, so the far side must hold it longer
  function automatic logic pick_trigger(
    input trig_origin_e origin,
    input trig_edge_e edge_kind,
    input logic [1:0] rise,
    input logic [1:0] fall,
    input logic sw
  );
    logic hit;
    hit = 1'b0;
    case (origin)
      origin_line_one: hit = (edge_kind == edge_down) ? fall[0] : rise[0];
      origin_line_two: hit = (edge_kind == edge_down) ? fall[1] : rise[1];
      origin_software: hit = sw;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  logic acq_go;
  logic frame_go;

  always_comb begin
    if (acq_trig_enable_sel) begin
      acq_go = pick_trigger(acq_trig_origin_sel, acq_trig_edge_sel, link.rise, link.fall, sw_acq);
    end else begin
      acq_go = 1'b1;
    end
  end

  always_comb begin
    if (frame_trig_enable_sel) begin
      frame_go = pick_trigger(frame_trig_origin_sel, frame_trig_edge_sel, link.rise, link.fall, sw_frame);
    end else begin
      frame_go = link.rate_tick;
    end
  end

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  // read data is captured in the setup cycle, so every access has
  // exactly one setup and one access cycle and pready stays high
  logic apb_setup;
  logic apb_write;
  logic addr_ok;
  logic missed_clear;
  logic total_clear;
  logic [31:0] read_value;

  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite;
  assign missed_clear = apb_write && paddr == `REG_MISSED;
  assign total_clear = apb_write && paddr == `REG_TOTAL;

  always_comb begin
    read_value = `DATA_RESET;
    addr_ok = 1'b1;
    case (paddr)
      `REG_CTRL: read_value[`CTRL_MSB:0] = ctrl;
      `REG_TRIG_CFG: read_value[`CFG_MSB:0] = trig_cfg;
      `REG_BURST: read_value[`COUNT_MSB:0] = frames_per_burst;
      `REG_RATE: read_value = internal_frame_rate;
      `REG_CMD: read_value = `DATA_RESET;
      `REG_STATUS: begin
        read_value[`STATUS_STATE_LSB +: 2] = state;
        read_value[`STATUS_EXPOSE] = (state == st_expose);
        read_value[`STATUS_COUNT_LSB +: 16] = frame_cnt;
      end
      `REG_MISSED: read_value[`COUNT_MSB:0] = missed_triggers;
      `REG_TOTAL: read_value = total_frames;
      `REG_PERIOD: read_value = frame_period;
      default: addr_ok = 1'b0;
    endcase
  end

  always_comb begin
    next_ctrl = ctrl;
    next_trig_cfg = trig_cfg;
    next_frames_per_burst = frames_per_burst;
    next_internal_frame_rate = internal_frame_rate;
    next_sw_acq = 1'b0;
    next_sw_frame = 1'b0;
    next_sw_abort = 1'b0;
    next_prdata = prdata_q;
    next_pslverr = pslverr_q;
    if (apb_setup) begin
      next_prdata = pwrite ? `DATA_RESET : read_value;
      next_pslverr = !addr_ok;
    end
    if (apb_write) begin
      case (paddr)
        `REG_CTRL: next_ctrl = pwdata[`CTRL_MSB:0];
        `REG_TRIG_CFG: next_trig_cfg = pwdata[`CFG_MSB:0];
        `REG_BURST: next_frames_per_burst = pwdata[`COUNT_MSB:0];
        `REG_RATE: next_internal_frame_rate = pwdata;
        `REG_CMD: begin
          next_sw_acq = pwdata[`CMD_ACQ_SW];
          next_sw_frame = pwdata[`CMD_FRAME_SW];
          next_sw_abort = pwdata[`CMD_ABORT];
        end
        default: next_ctrl = ctrl;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl <= `CTRL_RESET;
      trig_cfg <= `CFG_RESET;
      frames_per_burst <= `BURST_RESET;
      internal_frame_rate <= `RATE_RESET;
      sw_acq <= 1'b0;
      sw_frame <= 1'b0;
      sw_abort <= 1'b0;
      prdata_q <= `DATA_RESET;
      pslverr_q <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      trig_cfg <= next_trig_cfg;
      frames_per_burst <= next_frames_per_burst;
      internal_frame_rate <= next_internal_frame_rate;
      sw_acq <= next_sw_acq;
      sw_frame <= next_sw_frame;
      sw_abort <= next_sw_abort;
      prdata_q <= next_prdata;
      pslverr_q <= next_pslverr;
    end
  end

  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------
  // acquisition sequencer
  // ----------------------------------------
  // a dropped trigger in the same cycle as a clear still counts
  always_comb begin
    next_state = state;
    next_frame_cnt = frame_cnt;
    next_expose_cnt = expose_cnt;
    next_frame_start = 1'b0;
    next_missed_triggers = missed_clear ? `COUNT_RESET : missed_triggers;
    next_total_frames = total_clear ? `TOTAL_RESET : total_frames;
    case (state)
      st_wait_acq: begin
        if (frame_go) begin
          next_missed_triggers = next_missed_triggers + `COUNT_STEP;
        end
        if (acq_go && !sw_abort) begin
          next_state = st_wait_frame;
          next_frame_cnt = `COUNT_RESET;
        end
      end
      st_wait_frame: begin
        // abort wins over a trigger in the same cycle
        if (sw_abort) begin
          next_state = st_wait_acq;
        end else if (frame_go) begin
          next_state = st_expose;
          next_frame_cnt = frame_cnt + `COUNT_STEP;
          next_total_frames = next_total_frames + `PERIOD_STEP;
          next_expose_cnt = `EXPOSE_CYCLES - `COUNT_STEP;
          next_frame_start = 1'b1;
        end
      end
      st_expose: begin
        if (frame_go) begin
          next_missed_triggers = next_missed_triggers + `COUNT_STEP;
        end
        if (sw_abort) begin
          next_state = st_wait_acq;
        end else if (expose_cnt != `COUNT_RESET) begin
          next_expose_cnt = expose_cnt - `COUNT_STEP;
        end else if (frame_cnt >= burst_target) begin
          next_state = st_wait_acq;
        end else begin
          next_state = st_wait_frame;
        end
      end
      default: next_state = st_wait_acq;
    endcase
  end

  // stays in st_wait_acq until a fresh start; nothing is remembered
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= st_wait_acq;
      frame_cnt <= `COUNT_RESET;
      expose_cnt <= `COUNT_RESET;
      missed_triggers <= `COUNT_RESET;
      total_frames <= `TOTAL_RESET;
      frame_start_q <= 1'b0;
    end else begin
      state <= next_state;
      frame_cnt <= next_frame_cnt;
      expose_cnt <= next_expose_cnt;
      missed_triggers <= next_missed_triggers;
      total_frames <= next_total_frames;
      frame_start_q <= next_frame_start;
    end
  end

  // ----------------------------------------
  // status outputs
  // ----------------------------------------
  assign frame_start = frame_start_q;
  assign exposure_active = (state == st_expose);
  assign acq_waiting = (state == st_wait_acq);
  assign frame_waiting = (state == st_wait_frame);

endmodule

`default_nettype wire

/* File: testbench/acq_trig_monitor.sv */
`default_nettype none

module acq_trig_monitor (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic frame_start,
  input wire logic exposure_active,
  input wire logic acq_waiting,
  input wire logic frame_waiting
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // exposure length counter
  // ----------------------------------------
  logic [7:0] exp_cnt;
  logic [7:0] next_exp_cnt;
  always_comb begin
    next_exp_cnt = exposure_active ? exp_cnt + 8'h01 : 8'h00;
  end
  always_ff @(posedge clk) begin
    exp_cnt <= nrst ? next_exp_cnt : 8'h00;
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  // no disable here: the reset edge itself is what is checked
  reset_state_a: assert property (@(posedge clk) !nrst |=> acq_waiting && !frame_start && !exposure_active)
    else $error("wrong state after reset");
  pulse_width_a: assert property (@(posedge clk) disable iff (!nrst) frame_start |=> !frame_start)
    else $error("frame start wider than one cycle");
  start_opens_a: assert property (@(posedge clk) disable iff (!nrst) frame_start == $rose(exposure_active))
    else $error("exposure not tied to frame start");
  exposure_len_a: assert property (@(posedge clk) disable iff (!nrst) $fell(exposure_active) |-> exp_cnt == 8'h40)
    else $error("exposure length wrong");
  exposure_cap_a: assert property (@(posedge clk) disable iff (!nrst) exp_cnt <= 8'h40)
    else $error("exposure runs too long");
  start_state_a: assert property (@(posedge clk) disable iff (!nrst) frame_start |-> !acq_waiting && !frame_waiting)
    else $error("frame start outside exposure");
  idle_blocks_a: assert property (@(posedge clk) disable iff (!nrst) acq_waiting |=> !frame_start && !exposure_active)
    else $error("frame taken while waiting for start");
  one_state_a: assert property (@(posedge clk) disable iff (!nrst) $onehot({acq_waiting, frame_waiting, exposure_active}))
    else $error("state flags not one-hot");
  exposure_end_a: assert property (@(posedge clk) disable iff (!nrst) $fell(exposure_active) |-> acq_waiting || frame_waiting)
    else $error("exposure ended into wrong state");
  bus_ready_a: assert property (@(posedge clk) disable iff (!nrst) psel && penable |-> pready)
    else $error("access phase not ready");
  unmapped_err_a: assert property (@(posedge clk) disable iff (!nrst) psel && !penable && paddr > 8'h20 |=> pslverr)
    else $error("unmapped access without error");
endmodule

`default_nettype wire

/* File: testbench/trig_source.sv */
`default_nettype none

module trig_source (
  input wire logic clk,
  input wire logic [1:0] fire,
  output logic line_one,
  output logic line_two
);
  timeunit 1ns;
  timeprecision 100ps;

  // each request gives a four-cycle high pulse: one rise and one fall
  logic [2:0] hold_one = 3'h0;
  logic [2:0] hold_two = 3'h0;
  initial line_one = 1'b0;
  initial line_two = 1'b0;
  always @(posedge clk) begin
    hold_one <= fire[0] ? 3'h4 : (hold_one != 3'h0 ? hold_one - 3'h1 : 3'h0);
    hold_two <= fire[1] ? 3'h4 : (hold_two != 3'h0 ? hold_two - 3'h1 : 3'h0);
    line_one <= fire[0] || hold_one > 3'h1;
    line_two <= fire[1] || hold_two > 3'h1;
  end
endmodule

`default_nettype wire

/* File: testbench/tb_acquisition_trigger_sequencer.sv */
`default_nettype none
`include "acq_trig_regs.svh"

module tb_acquisition_trigger_sequencer;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic line_one, line_two, frame_start, exposure_active, acq_waiting, frame_waiting;
  logic [1:0] fire;
  int n_fail = 0;
  int compares = 0;
  int n_frames = 0;
  int cycles = 0;

  acquisition_trigger_sequencer i_acquisition_trigger_sequencer (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .ext_input_one(line_one),
    .ext_input_two(line_two), .frame_start(frame_start), .exposure_active(exposure_active),
    .acq_waiting(acq_waiting), .frame_waiting(frame_waiting));

  trig_source i_trig_source (.clk(clk), .fire(fire), .line_one(line_one), .line_two(line_two));

  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  always @(posedge clk) begin
    if (frame_start === 1'b1) begin
      n_frames <= n_frames + 1;
    end
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_fail++;
      summarize();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic summarize();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // release costs one idle cycle so psel is never assigned twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp);
    check({31'h0, e}, {31'h0, exp_err});
  endtask

  task automatic pulse(input int i);
    fire[i] <= 1'b1;
    @(posedge clk);
    fire[i] <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    while (acq_waiting !== 1'b1 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    check({31'h0, acq_waiting}, 32'h1);
  endtask

  task automatic gap(output int g);
    int k;
    k = 0;
    while (frame_start !== 1'b1 && k < 2000) begin
      @(posedge clk);
      k++;
    end
    g = 0;
    do begin
      @(posedge clk);
      g++;
    end while (frame_start !== 1'b1 && g < 2000);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int g;
    int base;
    int rates[3] = '{256, 81, 32};
    int periods[3] = '{256, 81, 80};
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fire = 2'b00;
    repeat (8) @(posedge clk);
    check({31'h0, acq_waiting}, 32'h1);
    nrst <= 1'b1;
    @(posedge clk);
    rd(`REG_CTRL, 32'h0, 1'b0);
    rd(`REG_BURST, 32'h1, 1'b0);
    rd(`REG_RATE, 32'h100, 1'b0);
    rd(8'h24, 32'h0, 1'b1);
    // free run; the first gap after a change straddles it, so measure the second
    gap(g);
    gap(g);
    check(g, 80);
    rd(`REG_PERIOD, 32'h50, 1'b0);
    wr(`REG_CTRL, 32'h4);
    for (int i = 0; i < 3; i++) begin
      wr(`REG_RATE, rates[i]);
      gap(g);
      gap(g);
      check(g, periods[i]);
    end
    // line one rising starts a burst of three internal frames
    wr(`REG_CTRL, 32'h1);
    wr(`REG_TRIG_CFG, 32'h0);
    wr(`REG_BURST, 32'h3);
    // abort only just after an exposure ends, so none is cut short
    g = 0;
    while (g < 200 || g == 300) begin
      @(posedge clk);
      g = (exposure_active === 1'b1) ? 300 : ((g == 300) ? 301 : g + 1);
    end
    wr(`REG_CMD, 32'h4);
    wait_idle();
    base = n_frames;
    repeat (300) @(posedge clk);
    check(n_frames - base, 0);
    pulse(0);
    repeat (20) @(posedge clk);
    check({31'h0, acq_waiting}, 32'h0);
    wait_idle();
    check(n_frames - base, 3);
    rd(`REG_STATUS, 32'h0003_0000, 1'b0);
    repeat (400) @(posedge clk);
    check(n_frames - base, 3);
    // single-frame mode, line two falling edge; count must restart
    wr(`REG_CTRL, 32'h9);
    wr(`REG_TRIG_CFG, 32'h5);
    pulse(1);
    repeat (20) @(posedge clk);
    wait_idle();
    check(n_frames - base, 4);
    rd(`REG_STATUS, 32'h0001_0000, 1'b0);
    // software start, line one frame triggers, one trigger lost in exposure
    wr(`REG_CTRL, 32'h3);
    wr(`REG_TRIG_CFG, 32'h2);
    wr(`REG_MISSED, 32'h0);
    base = n_frames;
    pulse(0);
    repeat (30) @(posedge clk);
    check(n_frames - base, 0);
    wr(`REG_CMD, 32'h1);
    repeat (4) @(posedge clk);
    check({31'h0, frame_waiting}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      pulse(0);
      repeat (10) @(posedge clk);
      if (i == 0) begin
        pulse(0);
      end
      repeat (100) @(posedge clk);
    end
    check(n_frames - base, 3);
    check({31'h0, acq_waiting}, 32'h1);
    rd(`REG_MISSED, 32'h2, 1'b0);
    pulse(0);
    repeat (100) @(posedge clk);
    check(n_frames - base, 3);
    // software origin for both start and frame triggers
    wr(`REG_TRIG_CFG, 32'h22);
    wr(`REG_CMD, 32'h1);
    for (int i = 0; i < 3; i++) begin
      wr(`REG_CMD, 32'h2);
      repeat (80) @(posedge clk);
    end
    check(n_frames - base, 6);
    check({31'h0, acq_waiting}, 32'h1);
    summarize();
  end
endmodule

bind acquisition_trigger_sequencer acq_trig_monitor i_acq_trig_monitor (
  .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .frame_start(frame_start), .exposure_active(exposure_active),
  .acq_waiting(acq_waiting), .frame_waiting(frame_waiting));

`default_nettype wire
